// file: hw/fcfg_regs.sv
// How it works
// [R1] interface mode code 11 is AT (default), 01 PS/2, 00 Model 30.
// [R2] interface mode field sits in mode register bits 3:2.
// [R3] mode bit 4 set swaps drive selects 0/1 and motor enables 0/1.
// [R4] mode bit 5 shuts core down; only output, tape, rate, config control writes pass.
// [R5] during shutdown pins float except densities, drive selects, motor enables.
// [R6] mode bit 6 clear drives pins open drain, 24 mA.
// [R7] mode bit 6 set drives pins push-pull, 24 mA.
// [R8] mode bit 7 set floats all dedicated floppy outputs; clear keeps them active.
// [R9] bits 6 and 7 leave parallel port floppy signals untouched.
// [R10] software writes zero to option bits 1:0; bits 5:4 reserved too.
// [R11] density field 00/01 normal, 10 forces ones, 11 forces zeros.
// [R12] option bits 7:6 pick boot drive 0 to 3, default drive 0.
// [R13] drive type register at f2: four two-bit fields, A lowest.
// [R14] reset returns every field to its default; option reads zero.
`timescale 1ns/100ps
`include "fcfg_consts.svh"

module fcfg_regs (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  // configuration port
  input  wire logic [7:0]             i_cfg_addr,
  input  wire logic [7:0]             i_cfg_wdata,
  input  wire logic                   i_cfg_wr,
  input  wire logic                   i_cfg_rd,
  output logic      [7:0]             o_cfg_rdata,
  // controller core write path
  input  wire logic [2:0]             i_core_addr,
  input  wire logic                   i_core_wr,
  output logic                        o_core_wr_allow,
  output logic                        o_core_shutdown,
  // controller core drive signals, same clock
  input  wire logic [1:0]             i_core_density,
  input  wire logic [1:0]             i_core_drive_select_n,
  input  wire logic [1:0]             i_core_motor_on_n,
  input  wire logic [4:0]             i_core_misc_out,
  // decoded configuration
  output fcfg_pkg::fcfg_ifm_t         o_if_mode,
  output logic [1:0]                  o_boot_drive,
  output logic [1:0]                  o_drive_a_type,
  output logic [1:0]                  o_drive_b_type,
  output logic [1:0]                  o_drive_c_type,
  output logic [1:0]                  o_drive_d_type,
  // dedicated floppy pins
  output logic                        o_density_out_0_o,
  output logic                        o_density_out_0_oe,
  output logic                        o_density_out_1_o,
  output logic                        o_density_out_1_oe,
  output logic                        o_drive_select_0_n_o,
  output logic                        o_drive_select_0_n_oe,
  output logic                        o_drive_select_1_n_o,
  output logic                        o_drive_select_1_n_oe,
  output logic                        o_motor_on_0_n_o,
  output logic                        o_motor_on_0_n_oe,
  output logic                        o_motor_on_1_n_o,
  output logic                        o_motor_on_1_n_oe,
  output logic [4:0]                  o_misc_o,
  output logic [4:0]                  o_misc_oe,
  // floppy signals routed through the parallel port
  output logic [`FCFG_NPINS-1:0]      o_pp_floppy_out
);

  import fcfg_pkg::*;

  fcfg_state_t                  st_r;
  fcfg_state_t                  st_nxt;

  logic                         swap;
  logic                         shutdown;
  logic                         push_pull;
  logic                         out_off;
  logic [1:0]                   den_sel;
  logic [1:0]                   den_lvl;
  logic [1:0]                   ds_lvl;
  logic [1:0]                   mtr_lvl;
  logic [`FCFG_NPINS-1:0]       pin_lvl;
  logic [`FCFG_NPINS-1:0]       pp_lvl;
  logic [`FCFG_NPINS-1:0]       pin_off;
  logic [`FCFG_NPINS-1:0]       drv_o;
  logic [`FCFG_NPINS-1:0]       drv_oe;
  logic                         core_addr_kept;

  // field decode from the stored registers
  assign swap      = st_r.mode_r[`FCFG_MODE_SWAP];
  assign shutdown  = st_r.mode_r[`FCFG_MODE_SHUTDOWN];
  assign push_pull = st_r.mode_r[`FCFG_MODE_PUSHPULL];
  assign out_off   = st_r.mode_r[`FCFG_MODE_OUT_OFF];
  assign den_sel   = st_r.option_r[`FCFG_OPT_DEN_HI:`FCFG_OPT_DEN_LO];

  // density forcing
  always_comb begin
    unique case (den_sel)
      `FCFG_DEN_FORCE_ONE:  den_lvl = 2'h3; // [R11]
      `FCFG_DEN_FORCE_ZERO: den_lvl = 2'h0; // [R11]
      default:              den_lvl = i_core_density;
    endcase
  end

  // drive 0/1 exchange
  always_comb begin
    if (swap) begin // [R3]
      ds_lvl  = {i_core_drive_select_n[0], i_core_drive_select_n[1]};
      mtr_lvl = {i_core_motor_on_n[0], i_core_motor_on_n[1]};
    end else begin
      ds_lvl  = i_core_drive_select_n;
      mtr_lvl = i_core_motor_on_n;
    end
  end

  assign pin_lvl = {i_core_misc_out, mtr_lvl, ds_lvl, den_lvl};

  // parallel port path sees raw core levels with swap and density applied
  // but never the driver type or tri-state settings
  assign pp_lvl = pin_lvl; // [R9]

  // per-pin float decision
  always_comb begin
    if (out_off) begin // [R8]
      pin_off = `FCFG_PINS_ONES;
    end else if (shutdown) begin // [R5]
      pin_off = ~`FCFG_SHUTDOWN_KEEP;
    end else begin
      pin_off = `FCFG_PINS_ZERO;
    end
  end

  fcfg_pin_drv u_pin_drv (
    .i_level     (pin_lvl),
    .i_off       (pin_off),
    .i_push_pull (push_pull),
    .o_pin_o     (drv_o),
    .o_pin_oe    (drv_oe)
  );

  // core write gating during shutdown
  always_comb begin
    unique case (i_core_addr)
      `FCFG_CORE_DIGITAL_OUTPUT_REG,
      `FCFG_CORE_TAPE_DRIVE_REG,
      `FCFG_CORE_DATA_RATE_REG,
      `FCFG_CORE_CONFIG_CONTROL_REG: core_addr_kept = 1'b1;
      default:                       core_addr_kept = 1'b0;
    endcase
  end

  // handshake style output, combinational so the core sees it in the same cycle
  assign o_core_wr_allow = i_core_wr & (~shutdown | core_addr_kept); // [R4]
  assign o_core_shutdown = shutdown; // [R4]

  // next state
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rdata_r  = `FCFG_RDATA_RST;

    // this bank stays writable in shutdown, else it could never be undone
    if (i_cfg_wr) begin
      unique case (i_cfg_addr)
        `FCFG_ADDR_MODE: begin // [R2]
          st_nxt.mode_r = i_cfg_wdata & `FCFG_MODE_WMASK;
        end
        `FCFG_ADDR_OPTION: begin // [R10]
          st_nxt.option_r = i_cfg_wdata & `FCFG_OPTION_WMASK;
        end
        `FCFG_ADDR_TYPE: begin // [R13]
          st_nxt.type_r = i_cfg_wdata & `FCFG_TYPE_WMASK;
        end
        default: begin
          st_nxt.mode_r = st_r.mode_r;
        end
      endcase
    end

    // read data valid only in the cycle after the strobe
    if (i_cfg_rd) begin
      unique case (i_cfg_addr)
        `FCFG_ADDR_MODE:   st_nxt.rdata_r = st_r.mode_r;
        `FCFG_ADDR_OPTION: st_nxt.rdata_r = st_r.option_r;
        `FCFG_ADDR_TYPE:   st_nxt.rdata_r = st_r.type_r; // [R13]
        default:           st_nxt.rdata_r = `FCFG_RDATA_RST;
      endcase
    end

    // pins are registered, adding one cycle of latency to the core levels
    st_nxt.pin_o_r  = drv_o;
    st_nxt.pin_oe_r = drv_oe;
    st_nxt.pp_o_r   = pp_lvl;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin // [R14]
      st_r.mode_r   <= `FCFG_MODE_RST;
      st_r.option_r <= `FCFG_OPTION_RST;
      st_r.type_r   <= `FCFG_TYPE_RST;
      st_r.rdata_r  <= `FCFG_RDATA_RST;
      st_r.pin_o_r  <= `FCFG_PINS_ZERO;
      st_r.pin_oe_r <= `FCFG_PINS_ZERO;
      st_r.pp_o_r   <= `FCFG_PINS_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

  // mode decode; reserved code 10 is reported as such
  assign o_if_mode = fcfg_ifm_t'(st_r.mode_r[`FCFG_MODE_IFM_HI:`FCFG_MODE_IFM_LO]); // [R1]

  assign o_boot_drive   = st_r.option_r[`FCFG_OPT_BOOT_HI:`FCFG_OPT_BOOT_LO]; // [R12]
  assign o_drive_a_type = st_r.type_r[`FCFG_TYPE_A_HI:`FCFG_TYPE_A_LO]; // [R13]
  assign o_drive_b_type = st_r.type_r[`FCFG_TYPE_B_HI:`FCFG_TYPE_B_LO];
  assign o_drive_c_type = st_r.type_r[`FCFG_TYPE_C_HI:`FCFG_TYPE_C_LO];
  assign o_drive_d_type = st_r.type_r[`FCFG_TYPE_D_HI:`FCFG_TYPE_D_LO];

  assign o_cfg_rdata = st_r.rdata_r;

  assign o_density_out_0_o     = st_r.pin_o_r[`FCFG_PIN_DEN0];
  assign o_density_out_0_oe    = st_r.pin_oe_r[`FCFG_PIN_DEN0];
  assign o_density_out_1_o     = st_r.pin_o_r[`FCFG_PIN_DEN1];
  assign o_density_out_1_oe    = st_r.pin_oe_r[`FCFG_PIN_DEN1];
  assign o_drive_select_0_n_o  = st_r.pin_o_r[`FCFG_PIN_DS0];
  assign o_drive_select_0_n_oe = st_r.pin_oe_r[`FCFG_PIN_DS0];
  assign o_drive_select_1_n_o  = st_r.pin_o_r[`FCFG_PIN_DS1];
  assign o_drive_select_1_n_oe = st_r.pin_oe_r[`FCFG_PIN_DS1];
  assign o_motor_on_0_n_o      = st_r.pin_o_r[`FCFG_PIN_MTR0];
  assign o_motor_on_0_n_oe     = st_r.pin_oe_r[`FCFG_PIN_MTR0];
  assign o_motor_on_1_n_o      = st_r.pin_o_r[`FCFG_PIN_MTR1];
  assign o_motor_on_1_n_oe     = st_r.pin_oe_r[`FCFG_PIN_MTR1];
  assign o_misc_o              = st_r.pin_o_r[`FCFG_PIN_MISC_HI:`FCFG_PIN_MISC_LO];
  assign o_misc_oe             = st_r.pin_oe_r[`FCFG_PIN_MISC_HI:`FCFG_PIN_MISC_LO];
  assign o_pp_floppy_out       = st_r.pp_o_r; // [R9]

endmodule : fcfg_regs

// file: hw/fcfg_consts.svh
`ifndef FCFG_CONSTS_SVH
`define FCFG_CONSTS_SVH

// register offsets on the configuration port
`define FCFG_ADDR_MODE        8'hf0
`define FCFG_ADDR_OPTION      8'hf1
`define FCFG_ADDR_TYPE        8'hf2

// reset values
`define FCFG_MODE_RST         8'h0c
`define FCFG_OPTION_RST       8'h00
`define FCFG_TYPE_RST         8'h00
`define FCFG_RDATA_RST        8'h00

// writable bits, reserved bits read as zero
`define FCFG_MODE_WMASK       8'hfc
`define FCFG_OPTION_WMASK     8'hcc
`define FCFG_TYPE_WMASK       8'hff

// floppy mode register fields
`define FCFG_MODE_IFM_HI      3
`define FCFG_MODE_IFM_LO      2
`define FCFG_MODE_SWAP        4
`define FCFG_MODE_SHUTDOWN    5
`define FCFG_MODE_PUSHPULL    6
`define FCFG_MODE_OUT_OFF     7

// floppy option register fields
`define FCFG_OPT_DEN_HI       3
`define FCFG_OPT_DEN_LO       2
`define FCFG_OPT_BOOT_HI      7
`define FCFG_OPT_BOOT_LO      6
`define FCFG_DEN_FORCE_ONE    2'h2
`define FCFG_DEN_FORCE_ZERO   2'h3

// interface mode codes
`define FCFG_IFM_CODE_AT      2'h3
`define FCFG_IFM_CODE_PS2     2'h1
`define FCFG_IFM_CODE_M30     2'h0

// drive type register fields, drive a lowest
`define FCFG_TYPE_A_HI        1
`define FCFG_TYPE_A_LO        0
`define FCFG_TYPE_B_HI        3
`define FCFG_TYPE_B_LO        2
`define FCFG_TYPE_C_HI        5
`define FCFG_TYPE_C_LO        4
`define FCFG_TYPE_D_HI        7
`define FCFG_TYPE_D_LO        6

// controller core register offsets still writable during shutdown
`define FCFG_CORE_DIGITAL_OUTPUT_REG  3'h2
`define FCFG_CORE_TAPE_DRIVE_REG      3'h3
`define FCFG_CORE_DATA_RATE_REG       3'h4
`define FCFG_CORE_CONFIG_CONTROL_REG  3'h7

// dedicated pin vector layout
`define FCFG_NPINS            11
`define FCFG_PIN_DEN0         0
`define FCFG_PIN_DEN1         1
`define FCFG_PIN_DS0          2
`define FCFG_PIN_DS1          3
`define FCFG_PIN_MTR0         4
`define FCFG_PIN_MTR1         5
`define FCFG_PIN_MISC_LO      6
`define FCFG_PIN_MISC_HI      10
`define FCFG_SHUTDOWN_KEEP    11'h03f
`define FCFG_PINS_ZERO        11'h000
`define FCFG_PINS_ONES        11'h7ff

`endif

// file: hw/fcfg_pkg.sv
package fcfg_pkg;

  typedef enum logic [1:0] {
    FCFG_IFM_M30,
    FCFG_IFM_PS2,
    FCFG_IFM_RSVD,
    FCFG_IFM_AT
  } fcfg_ifm_t;

  typedef struct packed {
    logic [7:0]  mode_r;
    logic [7:0]  option_r;
    logic [7:0]  type_r;
    logic [7:0]  rdata_r;
    logic [10:0] pin_o_r;
    logic [10:0] pin_oe_r;
    logic [10:0] pp_o_r;
  } fcfg_state_t;

endpackage : fcfg_pkg

// file: hw/fcfg_pin_drv.sv
`timescale 1ns/100ps
`include "fcfg_consts.svh"

module fcfg_pin_drv (
  input  wire logic [`FCFG_NPINS-1:0] i_level,
  input  wire logic [`FCFG_NPINS-1:0] i_off,
  input  wire logic                   i_push_pull,
  output logic      [`FCFG_NPINS-1:0] o_pin_o,
  output logic      [`FCFG_NPINS-1:0] o_pin_oe
);

  genvar g;
  generate
    for (g = 0; g < `FCFG_NPINS; g++) begin : g_pin
      // open drain only ever pulls low; a high level is left to the pull-up
      always_comb begin
        if (i_off[g]) begin
          o_pin_o[g]  = 1'b0;
          o_pin_oe[g] = 1'b0;
        end else if (i_push_pull) begin // [R7]
          o_pin_o[g]  = i_level[g];
          o_pin_oe[g] = 1'b1;
        end else begin // [R6]
          o_pin_o[g]  = 1'b0;
          o_pin_oe[g] = ~i_level[g];
        end
      end
    end
  endgenerate

endmodule : fcfg_pin_drv

// file: tb/fcfg_drive_model.sv
`timescale 1ns/100ps
// cable side of the dedicated pins: pull-ups on every line, so a
// released or open-drain-high pin reads one, never the last value
module fcfg_drive_model (
  input  wire logic [10:0] i_pin_o,
  input  wire logic [10:0] i_pin_oe,
  output logic      [10:0] o_level
);
  always_comb begin
    for (int k = 0; k < 11; k++) begin
      o_level[k] = i_pin_oe[k] ? i_pin_o[k] : 1'h1;
    end
  end
endmodule : fcfg_drive_model

// file: tb/fcfg_regs_assertions.sv
`timescale 1ns/100ps
module fcfg_regs_checker (
  input wire logic                i_sys_clk,
  input wire logic                i_rst,
  input wire logic [7:0]          i_cfg_addr,
  input wire logic [7:0]          i_cfg_wdata,
  input wire logic                i_cfg_wr,
  input wire logic                i_cfg_rd,
  input wire logic [7:0]          o_cfg_rdata,
  input wire logic [2:0]          i_core_addr,
  input wire logic                i_core_wr,
  input wire logic                o_core_wr_allow,
  input wire logic                o_core_shutdown,
  input wire logic [1:0]          i_core_drive_select_n,
  input wire logic [4:0]          i_core_misc_out,
  input wire fcfg_pkg::fcfg_ifm_t o_if_mode,
  input wire logic [1:0]          o_boot_drive,
  input wire logic                o_density_out_0_o,
  input wire logic                o_density_out_0_oe,
  input wire logic [4:0]          o_misc_oe,
  input wire logic [10:0]         o_pp_floppy_out
);
  logic [7:0] m_r;
  logic       live_r;
  // mirror of the mode register; live_r skips the edge right after reset
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      m_r <= 8'h0c;
      live_r <= 1'h0;
    end else begin
      live_r <= 1'h1;
      if (i_cfg_wr && i_cfg_addr == 8'hf0) m_r <= i_cfg_wdata;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_rd_idle; !i_cfg_rd |=> o_cfg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  property p_ifm; i_cfg_wr && i_cfg_addr == 8'hf0 |=> o_if_mode == $past(i_cfg_wdata[3:2]); endproperty
  a_ifm: assert property (p_ifm) else $error("interface mode wrong");
  property p_boot; i_cfg_wr && i_cfg_addr == 8'hf1 |=> o_boot_drive == $past(i_cfg_wdata[7:6]); endproperty
  a_boot: assert property (p_boot) else $error("boot drive wrong");
  property p_gate;
    o_core_wr_allow == (i_core_wr && (!o_core_shutdown || i_core_addr inside {3'h2, 3'h3, 3'h4, 3'h7}));
  endproperty
  a_gate: assert property (p_gate) else $error("core write gate wrong");
  property p_shut; live_r && $past(m_r[5]) |-> o_misc_oe == 5'h00; endproperty
  a_shut: assert property (p_shut) else $error("misc pins driven in shutdown");
  property p_swap;
    live_r |-> o_pp_floppy_out[3:2] == ($past(m_r[4]) ? {$past(i_core_drive_select_n[0]),
      $past(i_core_drive_select_n[1])} : $past(i_core_drive_select_n));
  endproperty
  a_swap: assert property (p_swap) else $error("drive select swap wrong");
  property p_od; live_r && !$past(m_r[6]) |-> !o_density_out_0_o; endproperty
  a_od: assert property (p_od) else $error("open drain pin drives high");
  property p_push; live_r && $past(m_r[6]) && !$past(m_r[7]) |-> o_density_out_0_oe; endproperty
  a_push: assert property (p_push) else $error("push-pull pin not driven");
  property p_off; live_r && $past(m_r[7]) |-> !o_density_out_0_oe && o_misc_oe == 5'h00; endproperty
  a_off: assert property (p_off) else $error("pins driven while off");
  property p_ppc; live_r |-> o_pp_floppy_out[10:6] == $past(i_core_misc_out); endproperty
  a_ppc: assert property (p_ppc) else $error("parallel copy wrong");
  c_shut: cover property (live_r && m_r[5] && i_core_wr);
  c_swap: cover property (live_r && m_r[4]);
  c_off: cover property (live_r && m_r[7]);
endmodule : fcfg_regs_checker
bind fcfg_regs fcfg_regs_checker chk_u (
  .i_sys_clk             (i_sys_clk),
  .i_rst                 (i_rst),
  .i_cfg_addr            (i_cfg_addr),
  .i_cfg_wdata           (i_cfg_wdata),
  .i_cfg_wr              (i_cfg_wr),
  .i_cfg_rd              (i_cfg_rd),
  .o_cfg_rdata           (o_cfg_rdata),
  .i_core_addr           (i_core_addr),
  .i_core_wr             (i_core_wr),
  .o_core_wr_allow       (o_core_wr_allow),
  .o_core_shutdown       (o_core_shutdown),
  .i_core_drive_select_n (i_core_drive_select_n),
  .i_core_misc_out       (i_core_misc_out),
  .o_if_mode             (o_if_mode),
  .o_boot_drive          (o_boot_drive),
  .o_density_out_0_o     (o_density_out_0_o),
  .o_density_out_0_oe    (o_density_out_0_oe),
  .o_misc_oe             (o_misc_oe),
  .o_pp_floppy_out       (o_pp_floppy_out)
);

// file: tb/floppy_config_registers_bench.sv
`timescale 1ns/100ps
module floppy_config_registers_bench;
  import fcfg_pkg::*;
  logic             i_sys_clk = '0, i_rst = '1, i_cfg_wr = '0, i_cfg_rd = '0, i_core_wr = '0;
  logic [7:0]       i_cfg_addr = '0, i_cfg_wdata = '0, o_cfg_rdata;
  logic [2:0]       i_core_addr = '0;
  logic [1:0]       i_core_density = '0, i_core_drive_select_n = '0, i_core_motor_on_n = '0;
  logic [4:0]       i_core_misc_out = '0, o_misc_o, o_misc_oe;
  logic             o_core_wr_allow, o_core_shutdown;
  fcfg_ifm_t        o_if_mode;
  logic [1:0]       o_boot_drive, o_drive_a_type, o_drive_b_type, o_drive_c_type, o_drive_d_type;
  logic             o_density_out_0_o, o_density_out_0_oe, o_density_out_1_o, o_density_out_1_oe;
  logic             o_drive_select_0_n_o, o_drive_select_0_n_oe, o_drive_select_1_n_o, o_drive_select_1_n_oe;
  logic             o_motor_on_0_n_o, o_motor_on_0_n_oe, o_motor_on_1_n_o, o_motor_on_1_n_oe;
  logic [10:0]      o_pp_floppy_out, lvl;
  logic [1:0]       ifm [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
  int               n_fail = 0, total_checks = 0;
  wire  [10:0]      po = {o_misc_o, o_motor_on_1_n_o, o_motor_on_0_n_o, o_drive_select_1_n_o,
                          o_drive_select_0_n_o, o_density_out_1_o, o_density_out_0_o};
  wire  [10:0]      poe = {o_misc_oe, o_motor_on_1_n_oe, o_motor_on_0_n_oe, o_drive_select_1_n_oe,
                           o_drive_select_0_n_oe, o_density_out_1_oe, o_density_out_0_oe};
  always #10 i_sys_clk = ~i_sys_clk;
  fcfg_regs dut_u (
    .i_sys_clk             (i_sys_clk),
    .i_rst                 (i_rst),
    .i_cfg_addr            (i_cfg_addr),
    .i_cfg_wdata           (i_cfg_wdata),
    .i_cfg_wr              (i_cfg_wr),
    .i_cfg_rd              (i_cfg_rd),
    .o_cfg_rdata           (o_cfg_rdata),
    .i_core_addr           (i_core_addr),
    .i_core_wr             (i_core_wr),
    .o_core_wr_allow       (o_core_wr_allow),
    .o_core_shutdown       (o_core_shutdown),
    .i_core_density        (i_core_density),
    .i_core_drive_select_n (i_core_drive_select_n),
    .i_core_motor_on_n     (i_core_motor_on_n),
    .i_core_misc_out       (i_core_misc_out),
    .o_if_mode             (o_if_mode),
    .o_boot_drive          (o_boot_drive),
    .o_drive_a_type        (o_drive_a_type),
    .o_drive_b_type        (o_drive_b_type),
    .o_drive_c_type        (o_drive_c_type),
    .o_drive_d_type        (o_drive_d_type),
    .o_density_out_0_o     (o_density_out_0_o),
    .o_density_out_0_oe    (o_density_out_0_oe),
    .o_density_out_1_o     (o_density_out_1_o),
    .o_density_out_1_oe    (o_density_out_1_oe),
    .o_drive_select_0_n_o  (o_drive_select_0_n_o),
    .o_drive_select_0_n_oe (o_drive_select_0_n_oe),
    .o_drive_select_1_n_o  (o_drive_select_1_n_o),
    .o_drive_select_1_n_oe (o_drive_select_1_n_oe),
    .o_motor_on_0_n_o      (o_motor_on_0_n_o),
    .o_motor_on_0_n_oe     (o_motor_on_0_n_oe),
    .o_motor_on_1_n_o      (o_motor_on_1_n_o),
    .o_motor_on_1_n_oe     (o_motor_on_1_n_oe),
    .o_misc_o              (o_misc_o),
    .o_misc_oe             (o_misc_oe),
    .o_pp_floppy_out       (o_pp_floppy_out)
  );
  fcfg_drive_model drv_u (.i_pin_o(po), .i_pin_oe(poe), .o_level(lvl));
  task automatic chk(input logic [10:0] s, input logic [10:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, s, e);
    end
  endtask : chk
  // write, then let the pin registers follow the new setting
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_cfg_addr <= a;
    i_cfg_wdata <= d;
    i_cfg_wr <= 1'h1;
    @(posedge i_sys_clk);
    i_cfg_wr <= 1'h0;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_cfg_addr <= a;
    i_cfg_rd <= 1'h1;
    @(posedge i_sys_clk);
    i_cfg_rd <= 1'h0;
    #1;
    chk(o_cfg_rdata, e);
  endtask : rd
  task automatic tally_and_finish;
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    i_core_density <= 2'h1;
    i_core_drive_select_n <= 2'h2;
    i_core_motor_on_n <= 2'h1;
    i_core_misc_out <= 5'h15;
    rd(8'hf0, 8'h0c);
    rd(8'hf1, 8'h00);
    rd(8'hf2, 8'h00);
    chk(o_if_mode, FCFG_IFM_AT);
    chk(poe[1:0], 2'h2);
    chk(lvl[1:0], 2'h1);
    for (int k = 0; k < 4; k++) begin
      wr(8'hf0, {4'h0, ifm[k], 2'h3});
      chk(o_if_mode, ifm[k]);
      rd(8'hf0, {4'h0, ifm[k], 2'h0});
    end
    wr(8'hf0, 8'h4c);
    chk(poe, 11'h7ff);
    chk(po[5:0], 6'h19);
    wr(8'hf0, 8'h5c);
    chk(po[5:2], 4'h9);
    chk(o_pp_floppy_out[5:2], 4'h9);
    wr(8'hf0, 8'h4c);
    wr(8'hf1, 8'hf8);
    rd(8'hf1, 8'hc8);
    chk(o_boot_drive, 2'h3);
    chk(po[1:0], 2'h3);
    wr(8'hf1, 8'h4c);
    chk(po[1:0], 2'h0);
    chk(o_boot_drive, 2'h1);
    wr(8'hf1, 8'h84);
    chk(po[1:0], 2'h1);
    chk(o_boot_drive, 2'h2);
    wr(8'hf1, 8'h00);
    chk(o_boot_drive, 2'h0);
    wr(8'hf2, 8'he4);
    chk({o_drive_d_type, o_drive_c_type, o_drive_b_type, o_drive_a_type}, 8'he4);
    rd(8'hf2, 8'he4);
    rd(8'hf3, 8'h00);
    wr(8'hf0, 8'h6c);
    chk(poe, 11'h03f);
    chk(o_core_shutdown, 1'h1);
    for (int k = 0; k < 8; k++) begin
      @(posedge i_sys_clk);
      i_core_addr <= 3'(k);
      i_core_wr <= 1'h1;
      #1;
      chk(o_core_wr_allow, k == 2 || k == 3 || k == 4 || k == 7);
    end
    @(posedge i_sys_clk);
    i_core_wr <= 1'h0;
    #1;
    chk(o_core_wr_allow, 1'h0);
    rd(8'hf0, 8'h6c);
    wr(8'hf0, 8'h8c);
    chk(poe, 11'h000);
    chk(lvl, 11'h7ff);
    chk(o_pp_floppy_out, 11'h559);
    @(posedge i_sys_clk);
    i_core_addr <= 3'h0;
    i_core_wr <= 1'h1;
    #1;
    chk(o_core_wr_allow, 1'h1);
    @(posedge i_sys_clk);
    i_core_wr <= 1'h0;
    @(posedge i_sys_clk);
    i_rst <= 1'h1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'h0;
    rd(8'hf0, 8'h0c);
    rd(8'hf2, 8'h00);
    tally_and_finish();
  end
endmodule : floppy_config_registers_bench
